// >>> hdl/gdp_config.sv
// How it works
// - Slew field 2 selects 125 V/us, 3 selects 200 V/us; 0 and 1 invalid.
// - Overvoltage threshold select: clear trips at 34 V, set trips at 22 V.
// - Overvoltage protection acts only while its enable bit is set.
// - Temperature warning drives the fault pin only while reporting is on.
// - Overcurrent must persist 0.2, 0.6, 1.1 or 1.6 us before acting.
// - Overcurrent threshold select: clear is 16 A, set is 24 A.
// - Response code 0 latches the overcurrent fault until cleared.
// - Response code 1 clears itself, retries after 500 ms; 2, 3 invalid.
// - Static sense gain codes 0 to 3 select 0.15, 0.3, 0.6, 1.2 V/A.
// - Static gain is ignored while automatic gain adjustment is enabled.
// - The configuration register sits at byte offset 0xAC.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module gdp_config #(
  parameter int unsigned RETRY_CYCLES = gdp_pkg::RETRY_CYC
) (
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_n_in,
  // APB slave
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [gdp_pkg::ADDR_W-1:0]  paddr_in,
  input  wire logic [31:0]                 pwdata_in,
  input  wire logic [3:0]                  pstrb_in,
  output var  logic [31:0]                 prdata_out,
  output var  logic                        pready_out,
  output var  logic                        pslverr_out,
  // Analog comparators and sensors (asynchronous)
  input  wire gdp_pkg::gdp_sense_type      sense_in,
  // Automatic gain from the gain tracker (same clock)
  input  wire logic [1:0]                  auto_gain_in,
  // Driver settings
  output var  logic                        slew_fast_out,
  output var  logic                        oc_thresh_high_out,
  output var  logic [1:0]                  sense_gain_out,
  output var  logic                        driver_disable_out,
  // Open-drain fault indication pin and interrupt
  output var  logic                        fault_pin_out,
  output var  logic                        fault_pin_oe_n_out,
  output var  logic                        irq_out
);

  localparam int unsigned RW = (RETRY_CYCLES > 1) ? $clog2(RETRY_CYCLES) : 1;

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  gdp_pkg::gdp_cfg_type      cfg;
  gdp_pkg::gdp_sense_type    sense_meta;
  gdp_pkg::gdp_sense_type    sense_sync;
  gdp_pkg::gdp_oc_state_type oc_state;
  gdp_pkg::gdp_oc_state_type next_oc_state;
  logic [4:0]                status;
  logic [4:0]                mask;
  logic                      auto_gain_en;
  logic [RW-1:0]             retry_cnt;
  logic                      ov_active_q;
  logic                      otw_q;
  logic                      oc_detect;
  logic [8:0]                oc_hi_cnt;

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdata,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire        access    = psel_in && penable_in;
  wire        done      = access && pready_out;
  wire        wr        = done && pwrite_in;
  wire        hit_cfg   = (paddr_in == gdp_pkg::CFG_ADDR);
  wire        hit_stat  = (paddr_in == gdp_pkg::STATUS_ADDR);
  wire        hit_mask  = (paddr_in == gdp_pkg::MASK_ADDR);
  wire        hit_ctrl  = (paddr_in == gdp_pkg::CTRL_ADDR);
  wire        hit_state = (paddr_in == gdp_pkg::STATE_ADDR);
  wire        mapped    = hit_cfg || hit_stat || hit_mask || hit_ctrl ||
                          hit_state;
  wire        wr_cfg    = wr && hit_cfg;
  wire        wr_stat   = wr && hit_stat && pstrb_in[0];
  wire        wr_mask   = wr && hit_mask;
  wire        wr_ctrl   = wr && hit_ctrl && pstrb_in[0];
  wire [31:0] cfg_new   = merge(cfg, pwdata_in, pstrb_in);
  wire [31:0] mask_new  = merge({27'h0, mask}, pwdata_in, pstrb_in);
  wire        fault_clr = wr_ctrl && pwdata_in[gdp_pkg::CTRL_CLEAR];

  // ---------------------------------------------------------------------
  // Protection logic
  // ---------------------------------------------------------------------
  wire ov_trip   = cfg.ov_sel ? sense_sync.ov_lo :
                   sense_sync.ov_hi;
  wire ov_active = cfg.ov_en && ov_trip;
  wire temp_warning_report_enable   = cfg.temp_rep && sense_sync.otw;
  wire [1:0] gain_sel  = auto_gain_en ? auto_gain_in : cfg.gain;
  wire oc_fault  = (oc_state != gdp_pkg::OC_RUN);
  wire fault_now = oc_fault || ov_active || temp_warning_report_enable;
  wire retry_end = (retry_cnt == RW'(RETRY_CYCLES - 1));
  wire slew_bad  = (cfg.slew != gdp_pkg::SLEW_125) &&
                   (cfg.slew != gdp_pkg::SLEW_200);
  // Invalid response codes fall back to latching: the safer of the two.
  wire resp_bad  = (cfg.resp != gdp_pkg::RESP_LATCH) &&
                   (cfg.resp != gdp_pkg::RESP_RETRY);
  wire cfg_bad   = wr_cfg &&
                   (((cfg_new[27:26] != gdp_pkg::SLEW_125) &&
                     (cfg_new[27:26] != gdp_pkg::SLEW_200)) ||
                    ((cfg_new[9:8] != gdp_pkg::RESP_LATCH) &&
                     (cfg_new[9:8] != gdp_pkg::RESP_RETRY)));

  wire [4:0] events;
  assign events[gdp_pkg::ST_OC]    = oc_detect && !oc_fault;
  assign events[gdp_pkg::ST_OV]    = ov_active && !ov_active_q;
  assign events[gdp_pkg::ST_OTW]   = sense_sync.otw && !otw_q;
  assign events[gdp_pkg::ST_RETRY] = (oc_state == gdp_pkg::OC_RETRY) &&
                                     retry_end;
  assign events[gdp_pkg::ST_CFG]   = cfg_bad;

  // A new event in the same cycle as its one-to-clear keeps its bit set.
  wire [4:0] status_clr = wr_stat ? pwdata_in[4:0] : 5'h00;
  wire [4:0] next_status = (status & ~status_clr) | events;

  wire [31:0] state_word = {26'h0, resp_bad, slew_bad, fault_now,
                            sense_sync.otw, ov_active, oc_fault};
  wire [31:0] rdata = hit_cfg   ? cfg :
                      hit_stat  ? {27'h0, status} :
                      hit_mask  ? {27'h0, mask} :
                      hit_ctrl  ? {31'h0, auto_gain_en} :
                      hit_state ? state_word : 32'h0000_0000;

  always_comb begin
    next_oc_state = oc_state;
    unique case (oc_state)
      gdp_pkg::OC_RUN: begin
        if (oc_detect) begin
          next_oc_state = (cfg.resp == gdp_pkg::RESP_RETRY) ?
                          gdp_pkg::OC_RETRY : gdp_pkg::OC_LATCH;
        end
      end
      gdp_pkg::OC_LATCH: begin
        if (fault_clr) begin
          next_oc_state = gdp_pkg::OC_RUN;
        end
      end
      gdp_pkg::OC_RETRY: begin
        if (retry_end || fault_clr) begin
          next_oc_state = gdp_pkg::OC_RUN;
        end
      end
    endcase
  end

  gdp_deglitch i_gdp_deglitch (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .level_in      (sense_sync.oc),
    .filter_sel_in (cfg.filter),
    .detect_out    (oc_detect)
  );

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      sense_meta  <= '0;
      sense_sync  <= '0;
      ov_active_q <= 1'b0;
      otw_q       <= 1'b0;
    end else begin
      sense_meta  <= sense_in;
      sense_sync  <= sense_meta;
      ov_active_q <= ov_active;
      otw_q       <= sense_sync.otw;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cfg          <= gdp_pkg::CFG_RESET;
      mask         <= gdp_pkg::STATUS_RESET;
      status       <= gdp_pkg::STATUS_RESET;
      auto_gain_en <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg <= cfg_new;
      end
      if (wr_mask) begin
        mask <= mask_new[4:0];
      end
      if (wr_ctrl) begin
        auto_gain_en <= pwdata_in[gdp_pkg::CTRL_AUTO];
      end
      status <= next_status;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      oc_state  <= gdp_pkg::OC_RUN;
      retry_cnt <= '0;
    end else begin
      oc_state  <= next_oc_state;
      retry_cnt <= (oc_state == gdp_pkg::OC_RETRY) && !retry_end ?
                   retry_cnt + RW'(1) : '0;
    end
  end

  // Zero-wait answers would need combinational outputs; one wait is paid.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= access && !pready_out;
      pslverr_out <= access && !pready_out && !mapped;
      prdata_out  <= (access && !pready_out && !pwrite_in) ? rdata :
                     32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      slew_fast_out      <= 1'b0;
      oc_thresh_high_out <= 1'b0;
      sense_gain_out     <= 2'h0;
      driver_disable_out <= 1'b0;
      fault_pin_out      <= 1'b0;
      fault_pin_oe_n_out <= 1'b1;
      irq_out            <= 1'b0;
    end else begin
      slew_fast_out      <= (cfg.slew == gdp_pkg::SLEW_200);
      oc_thresh_high_out <= cfg.oc_sel;
      sense_gain_out     <= gain_sel;
      driver_disable_out <= oc_fault || ov_active;
      fault_pin_out      <= 1'b0;
      fault_pin_oe_n_out <= !fault_now;
      irq_out            <= |(next_status & mask);
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      oc_hi_cnt <= 9'h000;
    end else begin
      oc_hi_cnt <= !sense_sync.oc ? 9'h000 :
                   (oc_hi_cnt == 9'h1FF) ? oc_hi_cnt : oc_hi_cnt + 9'h001;
    end
  end

  property p_slew;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg.slew == gdp_pkg::SLEW_200) ##1 (cfg.slew == gdp_pkg::SLEW_200)
      |-> slew_fast_out;
  endproperty
  a_slew: assert property (p_slew)
    else $error("Slew select does not follow code 3.");

  property p_ov_sel;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (cfg.ov_en && (cfg.ov_sel ? sense_sync.ov_lo : sense_sync.ov_hi))
      |=> driver_disable_out;
  endproperty
  a_ov_sel: assert property (p_ov_sel)
    else $error("Overvoltage at selected threshold did not disable driver.");

  property p_ov_off;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!cfg.ov_en && oc_state == gdp_pkg::OC_RUN) |=> !driver_disable_out;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("Driver disabled with overvoltage protection off.");

  property p_otw;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!cfg.temp_rep && !ov_active && oc_state == gdp_pkg::OC_RUN)
      |=> fault_pin_oe_n_out;
  endproperty
  a_otw: assert property (p_otw)
    else $error("Fault pin driven with no reportable fault.");

  property p_filter;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(oc_detect) |-> (oc_hi_cnt >= gdp_pkg::deg_cycles($past(cfg.filter)));
  endproperty
  a_filter: assert property (p_filter)
    else $error("Overcurrent acted on before the filter time.");

  property p_oc_sel;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $changed(cfg.oc_sel) |=> (oc_thresh_high_out == $past(cfg.oc_sel));
  endproperty
  a_oc_sel: assert property (p_oc_sel)
    else $error("Overcurrent threshold select not applied.");

  property p_latch;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (oc_state == gdp_pkg::OC_LATCH && !fault_clr) |=>
      (oc_state == gdp_pkg::OC_LATCH) && driver_disable_out;
  endproperty
  a_latch: assert property (p_latch)
    else $error("Latched overcurrent fault released without a clear.");

  property p_retry;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (oc_state == gdp_pkg::OC_RETRY && retry_cnt == '0 && !fault_clr) |=>
      (oc_state == gdp_pkg::OC_RETRY);
  endproperty
  a_retry: assert property (p_retry)
    else $error("Retry ended early.");

  property p_retry_end;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (oc_state == gdp_pkg::OC_RETRY && retry_end) |=>
      (oc_state == gdp_pkg::OC_RUN) && status[gdp_pkg::ST_RETRY];
  endproperty
  a_retry_end: assert property (p_retry_end)
    else $error("Retry did not resume operation after the delay.");

  property p_gain;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !auto_gain_en |=> (sense_gain_out == $past(cfg.gain));
  endproperty
  a_gain: assert property (p_gain)
    else $error("Static gain not applied.");

  property p_auto;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    auto_gain_en |=> (sense_gain_out == $past(auto_gain_in));
  endproperty
  a_auto: assert property (p_auto)
    else $error("Static gain used while automatic gain is on.");

  property p_cfg_wr;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (done && pwrite_in && paddr_in == gdp_pkg::CFG_ADDR && pstrb_in == 4'hF)
      |=> (cfg == $past(pwdata_in));
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("Configuration write at its offset not stored.");

endmodule

`default_nettype wire

// >>> hdl/gdp_deglitch.sv
`timescale 1ns/100ps
`default_nettype none

module gdp_deglitch (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  // Condition and filter selection
  input  wire logic       level_in,
  input  wire logic [1:0] filter_sel_in,
  // Qualified condition
  output var  logic       detect_out
);

  logic [8:0] cnt;
  logic [8:0] need;
  logic       reached;
  logic [8:0] next_cnt;

  assign need     = gdp_pkg::deg_cycles(filter_sel_in);
  assign reached  = (cnt >= (need - 9'h001));
  // A single low sample restarts the wait, so short spikes never count.
  assign next_cnt = !level_in ? 9'h000 :
                    reached   ? cnt    : cnt + 9'h001;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt        <= 9'h000;
      detect_out <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      detect_out <= level_in && reached;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/gdp_pkg.sv
`default_nettype none

package gdp_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  CFG_ADDR    = 8'hAC;
  localparam logic [7:0]  STATUS_ADDR = 8'hB0;
  localparam logic [7:0]  MASK_ADDR   = 8'hB4;
  localparam logic [7:0]  CTRL_ADDR   = 8'hB8;
  localparam logic [7:0]  STATE_ADDR  = 8'hBC;
  localparam logic [31:0] CFG_RESET   = 32'h1022_8100;

  // Event bits, shared by the status and mask registers.
  localparam int unsigned ST_OC    = 0;
  localparam int unsigned ST_OV    = 1;
  localparam int unsigned ST_OTW   = 2;
  localparam int unsigned ST_RETRY = 3;
  localparam int unsigned ST_CFG   = 4;
  localparam int unsigned STATUS_W = 5;
  localparam logic [4:0]  STATUS_RESET = 5'h00;

  // Control register bits.
  localparam int unsigned CTRL_AUTO  = 0;
  localparam int unsigned CTRL_CLEAR = 1;

  // Field encodings.
  localparam logic [1:0] SLEW_125   = 2'h2;
  localparam logic [1:0] SLEW_200   = 2'h3;
  localparam logic [1:0] RESP_LATCH = 2'h0;
  localparam logic [1:0] RESP_RETRY = 2'h1;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned DEG0_NS       = 200;
  localparam int unsigned DEG1_NS       = 600;
  localparam int unsigned DEG2_NS       = 1100;
  localparam int unsigned DEG3_NS       = 1600;
  localparam int unsigned DEG_CNT_W     = 9;
  localparam logic [8:0]  DEG0_CYC =
    9'((DEG0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0]  DEG1_CYC =
    9'((DEG1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0]  DEG2_CYC =
    9'((DEG2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0]  DEG3_CYC =
    9'((DEG3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned RETRY_MS      = 500;
  localparam int unsigned RETRY_CYC     =
    (RETRY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       parity;
    logic [1:0] rsv_a;
    logic       rsv_b;
    logic [1:0] slew;
    logic [5:0] rsv_c;
    logic       ov_sel;
    logic       ov_en;
    logic       rsv_d;
    logic       temp_rep;
    logic [1:0] rsv_e;
    logic [1:0] filter;
    logic       rsv_f;
    logic       oc_sel;
    logic [1:0] resp;
    logic [5:0] rsv_g;
    logic [1:0] gain;
  } gdp_cfg_type;

  typedef struct packed {
    logic       oc;
    logic       ov_hi;
    logic       ov_lo;
    logic       otw;
  } gdp_sense_type;

  typedef enum logic [2:0] {
    OC_RUN   = 3'b001,
    OC_LATCH = 3'b010,
    OC_RETRY = 3'b100
  } gdp_oc_state_type;

  function automatic logic [8:0] deg_cycles(input logic [1:0] code);
    logic [8:0] c;
    c = DEG0_CYC;
    case (code)
      2'h1:    c = DEG1_CYC;
      2'h2:    c = DEG2_CYC;
      2'h3:    c = DEG3_CYC;
      default: c = DEG0_CYC;
    endcase
    return c;
  endfunction

endpackage

`default_nettype wire

// >>> testbench/test_gdp_config.sv
`timescale 1ns/100ps
`default_nettype none

module test_gdp_config;

  // -------------------------------------------------------------------
  // Stimulus and observed signals
  // -------------------------------------------------------------------
  // A short retry wait keeps the run brief; expectations use this value.
  localparam int unsigned RETRY = 20;
  localparam int unsigned DEG_NS [4] = '{gdp_pkg::DEG0_NS, gdp_pkg::DEG1_NS,
                                         gdp_pkg::DEG2_NS, gdp_pkg::DEG3_NS};

  logic                   core_clk_in = 1'b0;
  logic                   rst_n_in    = 1'b0;
  logic                   psel        = 1'b0;
  logic                   penable     = 1'b0;
  logic                   pwrite      = 1'b0;
  logic [7:0]             paddr       = 8'h00;
  logic [31:0]            pwdata      = 32'h0000_0000;
  logic [3:0]             pstrb       = 4'hF;
  gdp_pkg::gdp_sense_type sense       = 4'h0;
  logic [1:0]             auto_gain   = 2'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   slew_fast;
  logic                   oc_hi;
  logic [1:0]             gain;
  logic                   dis;
  logic                   pin;
  logic                   pin_oe_n;
  logic                   irq;
  gdp_pkg::gdp_cfg_type   cfg;
  logic [31:0]            rd;
  logic                   err;
  int                     bad_count = 0;
  int                     n_tests   = 0;
  int                     n_deg;

  always #2.5 core_clk_in = ~core_clk_in;

  gdp_config #(.RETRY_CYCLES(RETRY)) i_gdp_config (
    .core_clk_in        (core_clk_in),
    .rst_n_in           (rst_n_in),
    .psel_in            (psel),
    .penable_in         (penable),
    .pwrite_in          (pwrite),
    .paddr_in           (paddr),
    .pwdata_in          (pwdata),
    .pstrb_in           (pstrb),
    .prdata_out         (prdata),
    .pready_out         (pready),
    .pslverr_out        (pslverr),
    .sense_in           (sense),
    .auto_gain_in       (auto_gain),
    .slew_fast_out      (slew_fast),
    .oc_thresh_high_out (oc_hi),
    .sense_gain_out     (gain),
    .driver_disable_out (dis),
    .fault_pin_out      (pin),
    .fault_pin_oe_n_out (pin_oe_n),
    .irq_out            (irq)
  );

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    @(posedge core_clk_in);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge core_clk_in);
      k++;
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) check(32'h0, 32'h1, "bus answer");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd, exp, "read data");
  endtask

  task automatic wait_dis(input logic lvl, input int lim);
    int k;
    k = 0;
    while (dis !== lvl && k < lim) begin
      tick(1);
      k++;
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------
  initial begin
    tick(20000);
    bad_count++;
    close_out();
  end

  initial begin
    cfg = gdp_pkg::CFG_RESET;
    tick(8);
    rst_n_in <= 1'b1;
    tick(1);
    rdc(gdp_pkg::CFG_ADDR, gdp_pkg::CFG_RESET);
    check(32'(pin_oe_n), 32'h1, "pin at reset");
    check(32'(dis), 32'h0, "disable at reset");
    check(32'(gain), 32'h0, "gain at reset");
    xfer(1'b0, 8'hF0, 32'h0000_0000);
    check(32'(err), 32'h1, "unmapped error");
    check(rd, 32'h0000_0000, "unmapped data");
    for (int i = 0; i < 4; i++) begin
      cfg.slew   = 2'(i);
      cfg.gain   = 2'(i);
      cfg.oc_sel = i[0];
      wr(gdp_pkg::CFG_ADDR, cfg);
      tick(3);
      check(32'(slew_fast), 32'(i == 3), "slew");
      check(32'(gain), 32'(i), "static gain");
      check(32'(oc_hi), 32'(i[0]), "oc threshold");
    end
    rdc(gdp_pkg::CFG_ADDR, cfg);
    check(32'(err), 32'h0, "mapped no error");
    rdc(gdp_pkg::STATUS_ADDR, 32'(1) << gdp_pkg::ST_CFG);
    auto_gain <= 2'h1;
    wr(gdp_pkg::CTRL_ADDR, 32'h0000_0001);
    tick(3);
    check(32'(gain), 32'h1, "auto gain");
    auto_gain <= 2'h2;
    tick(3);
    check(32'(gain), 32'h2, "auto gain");
    wr(gdp_pkg::CTRL_ADDR, 32'h0000_0000);
    tick(3);
    check(32'(gain), 32'h3, "static again");
    sense.ov_hi <= 1'b1;
    sense.ov_lo <= 1'b1;
    tick(8);
    check(32'(dis), 32'h0, "ov disabled");
    cfg.ov_en = 1'b1;
    wr(gdp_pkg::CFG_ADDR, cfg);
    tick(6);
    check(32'(dis), 32'h1, "ov 34 V");
    sense.ov_hi <= 1'b0;
    tick(8);
    check(32'(dis), 32'h0, "below 34 V");
    cfg.ov_sel = 1'b1;
    wr(gdp_pkg::CFG_ADDR, cfg);
    tick(6);
    check(32'(dis), 32'h1, "ov 22 V");
    sense.ov_lo <= 1'b0;
    cfg.ov_en   = 1'b0;
    wr(gdp_pkg::CFG_ADDR, cfg);
    wr(gdp_pkg::STATUS_ADDR, 32'h0000_001F);
    wr(gdp_pkg::MASK_ADDR, 32'(1) << gdp_pkg::ST_OTW);
    sense.otw <= 1'b1;
    tick(6);
    check(32'(pin_oe_n), 32'h1, "warning hidden");
    check(32'(irq), 32'h1, "irq raised");
    cfg.temp_rep = 1'b1;
    wr(gdp_pkg::CFG_ADDR, cfg);
    tick(4);
    check(32'(pin_oe_n), 32'h0, "warning shown");
    wr(gdp_pkg::MASK_ADDR, 32'h0000_0000);
    tick(2);
    check(32'(irq), 32'h0, "irq masked");
    wr(gdp_pkg::MASK_ADDR, 32'(1) << gdp_pkg::ST_OTW);
    wr(gdp_pkg::STATUS_ADDR, 32'(1) << gdp_pkg::ST_OTW);
    tick(2);
    check(32'(irq), 32'h0, "irq cleared");
    sense.otw    <= 1'b0;
    cfg.temp_rep = 1'b0;
    cfg.resp     = gdp_pkg::RESP_LATCH;
    for (int i = 0; i < 4; i++) begin
      cfg.filter = 2'(i);
      wr(gdp_pkg::CFG_ADDR, cfg);
      n_deg = (DEG_NS[i] + gdp_pkg::CLK_PERIOD_NS - 1) /
              gdp_pkg::CLK_PERIOD_NS;
      sense.oc <= 1'b1;
      tick(n_deg - 2);
      sense.oc <= 1'b0;
      tick(10);
      check(32'(dis), 32'h0, "short glitch");
      sense.oc <= 1'b1;
      tick(n_deg);
      check(32'(dis), 32'h0, "too early");
      wait_dis(1'b1, 12);
      check(32'(dis), 32'h1, "oc detected");
      check(32'(pin_oe_n), 32'h0, "fault shown");
      check(32'(pin), 32'h0, "pin data low");
      sense.oc <= 1'b0;
      tick(30);
      check(32'(dis), 32'h1, "fault latched");
      rdc(gdp_pkg::STATE_ADDR, 32'h0000_0009);
      rdc(gdp_pkg::STATUS_ADDR, 32'h0000_0001);
      wr(gdp_pkg::STATUS_ADDR, 32'h0000_0001);
      wr(gdp_pkg::CTRL_ADDR, 32'h0000_0002);
      tick(4);
      check(32'(dis), 32'h0, "fault cleared");
    end
    cfg.filter = 2'h0;
    cfg.resp   = gdp_pkg::RESP_RETRY;
    wr(gdp_pkg::CFG_ADDR, cfg);
    sense.oc <= 1'b1;
    wait_dis(1'b1, 60);
    sense.oc <= 1'b0;
    check(32'(dis), 32'h1, "retry fault");
    tick(RETRY - 4);
    check(32'(dis), 32'h1, "retry wait");
    wait_dis(1'b0, 12);
    check(32'(dis), 32'h0, "retry done");
    xfer(1'b0, gdp_pkg::STATUS_ADDR, 32'h0000_0000);
    check(32'(rd[gdp_pkg::ST_RETRY]), 32'h1, "retry event");
    close_out();
  end

endmodule

`default_nettype wire
